// ==== hw/bus_clock_setup.sv ====
// Transfer clock selection, line monitor, noise filter and pin setup
module bus_clock_setup #(
  parameter int FILT_LEN = bus_clock_pkg::FILTER_LEN
) (
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // CPU register access
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  // From the main control register
  input  wire logic        interface_enable,
  // From the serial engine: pull the line low
  input  wire logic        clock_function_low,
  input  wire logic        data_function_low,
  // To the serial engine
  output logic             selection_tick,
  output logic             transfer_clock,
  output logic             clock_level,
  output logic             data_level,
  // Open-drain pins
  input  wire logic        serial_clock_line_in,
  output logic             serial_clock_line_out,
  output logic             serial_clock_line_oe,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]      s1;
    logic [1:0]      s2;
    logic [1:0]      flt;
    logic [1:0][2:0] fcnt;
    logic            cld;
    logic            dad;
    logic [3:0]      sel;
    logic            clx;
    logic [2:0]      dir;
    logic [1:0]      latch;
    logic [7:0]      rdata;
    logic [1:0]      pre;
    logic            tick;
    logic [6:0]      tcnt;
    logic            tclk;
    logic [1:0]      oe;
    logic [1:0]      lout;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [1:0] pin_in;
  logic [1:0] fn_low;
  logic [6:0] cur_m;
  logic [1:0] pre_last;
  logic       filt_on;
  logic       hs;

  assign pin_in = {serial_data_line_in, serial_clock_line_in};
  assign fn_low = {data_function_low, clock_function_low};
  assign hs     = st_r.sel[bus_clock_pkg::SPEED_MODE_BIT];
  // Filter only acts in high-speed mode
  assign filt_on = hs && st_r.sel[bus_clock_pkg::FILTER_EN_BIT];

  // ---------------------------------------------------------------
  // Divisor selection
  // ---------------------------------------------------------------
  // Prescaler: high select bit picks /4, else /2
  always_comb begin
    if (st_r.sel[bus_clock_pkg::SEL_HIGH_BIT]) begin
      pre_last = bus_clock_pkg::PRE_DIV4_LAST;
    end else begin
      pre_last = bus_clock_pkg::PRE_DIV2_LAST;
    end
  end

  // Divisor m; the filter bit plays no part
  always_comb begin
    if (hs && st_r.clx) begin
      cur_m = bus_clock_pkg::M_HIGH_EXPAND;
    end else if (hs) begin
      cur_m = bus_clock_pkg::M_HIGH_SPEED;
    end else if (st_r.sel[1:0] == 2'h0) begin
      cur_m = bus_clock_pkg::M_NORMAL_FAST;
    end else begin
      cur_m = bus_clock_pkg::M_NORMAL_SLOW;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // Two-flop synchronisers on the pins
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;

    // Noise filter per line
    for (int i = 0; i < 2; i++) begin
      if (!filt_on || st_r.s2[i] == st_r.flt[i]) begin
        st_nxt.fcnt[i] = 3'h0;
        st_nxt.flt[i]  = st_r.s2[i];
      end else if (st_r.fcnt[i] >= 3'(FILT_LEN - 1)) begin
        st_nxt.fcnt[i] = 3'h0;
        st_nxt.flt[i]  = st_r.s2[i];
      end else begin
        st_nxt.fcnt[i] = st_r.fcnt[i] + 3'h1;
      end
    end

    // Line-level flags, cleared while disabled
    st_nxt.cld = interface_enable && st_r.s2[bus_clock_pkg::CLK_PIN];
    st_nxt.dad = interface_enable && st_r.s2[bus_clock_pkg::DATA_PIN];

    // Prescaler and transfer clock, held idle while disabled
    st_nxt.tick = 1'b0;
    if (!interface_enable) begin
      st_nxt.pre  = 2'h0;
      st_nxt.tcnt = 7'h0;
      st_nxt.tclk = 1'b0;
    end else if (st_r.pre >= pre_last) begin
      st_nxt.pre  = 2'h0;
      st_nxt.tick = 1'b1;
      // Half period is m/2 selection-clock cycles
      if (st_r.tcnt >= cur_m[6:1] - 7'h1) begin
        st_nxt.tcnt = 7'h0;
        st_nxt.tclk = !st_r.tclk;
      end else begin
        st_nxt.tcnt = st_r.tcnt + 7'h1;
      end
    end else begin
      st_nxt.pre = st_r.pre + 2'h1;
    end

    // Pin drivers: open drain, only ever pull low
    for (int i = 0; i < 2; i++) begin
      st_nxt.lout[i] = 1'b0;
      if (st_r.dir[i]) begin
        st_nxt.oe[i] = 1'b0;
      end else if (!interface_enable) begin
        st_nxt.oe[i] = 1'b1;
      end else if (st_r.latch[i]) begin
        st_nxt.oe[i] = 1'b0;
      end else begin
        st_nxt.oe[i] = fn_low[i];
      end
    end

    // Register writes
    if (cpu_wr) begin
      if (cpu_addr == bus_clock_pkg::ADDR_PORT_SIX_DATA) begin
        st_nxt.latch = cpu_wdata[1:0];
      end else if (cpu_addr == bus_clock_pkg::ADDR_PORT_SIX_DIR) begin
        st_nxt.dir = cpu_wdata[2:0];
      end else if (cpu_addr == bus_clock_pkg::ADDR_CLK_SELECT) begin
        st_nxt.sel = cpu_wdata[3:0];
      end else if (cpu_addr == bus_clock_pkg::ADDR_CLK_EXPANSION) begin
        st_nxt.clx = cpu_wdata[bus_clock_pkg::EXPANSION_BIT];
      end
    end

    // Register reads
    if (cpu_rd) begin
      if (cpu_addr == bus_clock_pkg::ADDR_PORT_SIX_DATA) begin
        st_nxt.rdata = 8'h00;
        for (int i = 0; i < 2; i++) begin
          st_nxt.rdata[i] = st_r.dir[i] ? st_r.s2[i] : st_r.latch[i];
        end
      end else if (cpu_addr == bus_clock_pkg::ADDR_PORT_SIX_DIR) begin
        st_nxt.rdata = {bus_clock_pkg::DIR_UNUSED_ONES, st_r.dir};
      end else if (cpu_addr == bus_clock_pkg::ADDR_CLK_SELECT) begin
        st_nxt.rdata = {2'h0, st_r.cld, st_r.dad, st_r.sel};
      end else if (cpu_addr == bus_clock_pkg::ADDR_CLK_EXPANSION) begin
        st_nxt.rdata = {7'h00, st_r.clx};
      end else begin
        st_nxt.rdata = bus_clock_pkg::READ_UNMAPPED;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r       <= '0;
      st_r.sel   <= bus_clock_pkg::RST_CLK_SELECT[3:0];
      st_r.clx   <= bus_clock_pkg::RST_CLK_EXPANSION[0];
      st_r.dir   <= bus_clock_pkg::RST_PORT_SIX_DIR[2:0];
      st_r.latch <= bus_clock_pkg::RST_PORT_SIX_DATA[1:0];
      st_r.s1    <= 2'h3;
      st_r.s2    <= 2'h3;
      st_r.flt   <= 2'h3;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cpu_rdata             = st_r.rdata;
  assign selection_tick        = st_r.tick;
  assign transfer_clock        = st_r.tclk;
  assign clock_level           = st_r.flt[bus_clock_pkg::CLK_PIN];
  assign data_level            = st_r.flt[bus_clock_pkg::DATA_PIN];
  assign serial_clock_line_out = st_r.lout[bus_clock_pkg::CLK_PIN];
  assign serial_clock_line_oe  = st_r.oe[bus_clock_pkg::CLK_PIN];
  assign serial_data_line_out  = st_r.lout[bus_clock_pkg::DATA_PIN];
  assign serial_data_line_oe   = st_r.oe[bus_clock_pkg::DATA_PIN];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_clock_flag_off: assert property (@(posedge mclk) disable iff (rst)
    (ce && !interface_enable) |=> !st_r.cld)
    else $error("clock flag set while disabled");

  a_data_flag_on: assert property (@(posedge mclk) disable iff (rst)
    (ce && interface_enable && st_r.s2[1]) |=> st_r.dad)
    else $error("data flag missed high line");

  a_flag_readback: assert property (@(posedge mclk) disable iff (rst)
    (ce && cpu_rd && cpu_addr == bus_clock_pkg::ADDR_CLK_SELECT)
      |=> cpu_rdata[5:4] == {$past(st_r.cld), $past(st_r.dad)} && cpu_rdata[7:6] == 2'h0)
    else $error("selection read lost line flags");

  a_disabled_low: assert property (@(posedge mclk) disable iff (rst)
    (ce && !interface_enable && !st_r.dir[0] && !st_r.dir[1])
      |=> serial_clock_line_oe && serial_data_line_oe && !serial_clock_line_out)
    else $error("pins not driven low while disabled");

  a_input_released: assert property (@(posedge mclk) disable iff (rst)
    (ce && st_r.dir[0]) |=> !serial_clock_line_oe)
    else $error("input mode pin still driven");

  a_latch_one: assert property (@(posedge mclk) disable iff (rst)
    (ce && interface_enable && !st_r.dir[1] && st_r.latch[1] && data_function_low)
      |=> !serial_data_line_oe)
    else $error("latch one did not release data line");

  a_port_read: assert property (@(posedge mclk) disable iff (rst)
    (ce && cpu_rd && cpu_addr == bus_clock_pkg::ADDR_PORT_SIX_DATA && st_r.dir[1])
      |=> cpu_rdata[1] == $past(st_r.s2[1]))
    else $error("port read did not return pin level");

  a_normal_div: assert property (@(posedge mclk) disable iff (rst)
    (!hs && st_r.sel[1:0] == 2'h1) |-> cur_m == 7'd86 && pre_last == 2'h1)
    else $error("normal mode divisor wrong");

  a_fast_div: assert property (@(posedge mclk) disable iff (rst)
    (hs && st_r.clx && st_r.sel[1:0] == 2'h2) |-> cur_m == 7'd12 && pre_last == 2'h3)
    else $error("expanded high-speed divisor wrong");

  a_tick_spacing: assert property (@(posedge mclk) disable iff (rst)
    (ce && interface_enable && st_r.tick && !st_r.sel[1]) |=> !st_r.tick)
    else $error("selection ticks too close");

  a_clock_flag_on: assert property (@(posedge mclk) disable iff (rst)
    (ce && interface_enable) |=> st_r.cld == $past(st_r.s2[bus_clock_pkg::CLK_PIN]))
    else $error("clock flag missed line level");

  a_data_flag_off: assert property (@(posedge mclk) disable iff (rst)
    (ce && !interface_enable) |=> !st_r.dad)
    else $error("data flag set while disabled");

  a_select_write: assert property (@(posedge mclk) disable iff (rst)
    (ce && cpu_wr && cpu_addr == bus_clock_pkg::ADDR_CLK_SELECT)
      |=> st_r.sel == $past(cpu_wdata[3:0]))
    else $error("selection write not stored as mode bits");

  a_speed_normal: assert property (@(posedge mclk) disable iff (rst)
    !hs |-> (cur_m == bus_clock_pkg::M_NORMAL_FAST
      || cur_m == bus_clock_pkg::M_NORMAL_SLOW))
    else $error("standard mode picked a high-speed divisor");

  a_high_div: assert property (@(posedge mclk) disable iff (rst)
    (hs && !st_r.clx && !st_r.sel[1]) |-> cur_m == 7'h18 && pre_last == 2'h1)
    else $error("high-speed divisor wrong");

  a_filter_passes: assert property (@(posedge mclk) disable iff (rst)
    (ce && !filt_on) |=> st_r.flt == $past(st_r.s2))
    else $error("filter acted while switched off");

  a_filter_holds: assert property (@(posedge mclk) disable iff (rst)
    (ce && filt_on && FILT_LEN > 1 && st_r.fcnt[1] == 3'h0
      && st_r.s2[1] != st_r.flt[1]) |=> st_r.flt[1] == $past(st_r.flt[1]))
    else $error("filter passed a one-cycle spike");

  a_tcnt_bound: assert property (@(posedge mclk) disable iff (rst)
    st_r.tcnt < {1'b0, cur_m[6:1]})
    else $error("half-period count overran");

  a_data_pin_low: assert property (@(posedge mclk) disable iff (rst)
    (ce && !interface_enable && !st_r.dir[1]) |=> serial_data_line_oe)
    else $error("data pin not driven low while disabled");

  a_func_pass: assert property (@(posedge mclk) disable iff (rst)
    (ce && interface_enable && !st_r.dir[0] && !st_r.latch[0])
      |=> serial_clock_line_oe == $past(clock_function_low))
    else $error("latch zero did not pass clock function");

  a_clock_latch_one: assert property (@(posedge mclk) disable iff (rst)
    (ce && interface_enable && !st_r.dir[0] && st_r.latch[0] && clock_function_low)
      |=> !serial_clock_line_oe)
    else $error("latch one did not release clock line");

  a_open_drain: assert property (@(posedge mclk) disable iff (rst)
    ce |=> !serial_clock_line_out && !serial_data_line_out)
    else $error("pin driven high");

  a_reset_select: assert property (@(posedge mclk) disable iff (rst)
    $past(rst) |-> st_r.sel == bus_clock_pkg::RST_CLK_SELECT[3:0] && !st_r.cld && !st_r.dad)
    else $error("selection not clear after reset");

endmodule

// ==== hw/bus_clock_pkg.sv ====
// Constants for the two-wire bus clock selection and pin setup block
package bus_clock_pkg;

  // ---------------------------------------------------------------
  // Register addresses in the CPU register space
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_PORT_SIX_DATA = 16'hff06;
  localparam logic [15:0] ADDR_PORT_SIX_DIR  = 16'hff26;
  localparam logic [15:0] ADDR_CLK_SELECT    = 16'hffa8;
  localparam logic [15:0] ADDR_CLK_EXPANSION = 16'hffa9;

  // ---------------------------------------------------------------
  // Reset values and the unmapped read value
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PORT_SIX_DATA = 8'h00;
  localparam logic [7:0] RST_PORT_SIX_DIR  = 8'hff;
  localparam logic [7:0] RST_CLK_SELECT    = 8'h00;
  localparam logic [7:0] RST_CLK_EXPANSION = 8'h00;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CLK_LINE_FLAG_BIT  = 5;
  localparam int DATA_LINE_FLAG_BIT = 4;
  localparam int SPEED_MODE_BIT     = 3;
  localparam int FILTER_EN_BIT      = 2;
  localparam int SEL_HIGH_BIT       = 1;
  localparam int SEL_LOW_BIT        = 0;
  localparam int EXPANSION_BIT      = 0;
  localparam int CLK_PIN            = 0;
  localparam int DATA_PIN           = 1;
  localparam int THIRD_PIN          = 2;
  localparam logic [4:0] DIR_UNUSED_ONES = 5'h1f;

  // ---------------------------------------------------------------
  // Prescaler terminal counts and transfer divisors
  // ---------------------------------------------------------------
  localparam logic [1:0] PRE_DIV2_LAST = 2'h1;
  localparam logic [1:0] PRE_DIV4_LAST = 2'h3;
  localparam logic [6:0] M_NORMAL_FAST = 7'd44;
  localparam logic [6:0] M_NORMAL_SLOW = 7'd86;
  localparam logic [6:0] M_HIGH_SPEED  = 7'd24;
  localparam logic [6:0] M_HIGH_EXPAND = 7'd12;

  // Noise filter: cycles a new level must hold before it is taken
  localparam int FILTER_LEN = 3;

endpackage

// ==== bench/bus_partner.sv ====
// Other bus devices and the pull-up resistors on the two lines
module bus_partner (
  // Open-drain drive from the block
  input  wire logic clock_oe,
  input  wire logic clock_out,
  input  wire logic data_oe,
  input  wire logic data_out,
  // Other devices holding a line low
  input  wire logic hold_clock_low,
  input  wire logic hold_data_low,
  // Resolved line levels
  output logic      clock_wire,
  output logic      data_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins unless some party pulls low
  assign clock_wire = !((clock_oe && !clock_out) || hold_clock_low);
  assign data_wire  = !((data_oe && !data_out) || hold_data_low);
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for transfer clock selection and pin setup
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------
  // Signals
  // -------------------------------------------------
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  logic        cpu_wr = 1'b0;
  logic        cpu_rd = 1'b0;
  logic [7:0]  cpu_wdata = 8'h00;
  logic        en = 1'b0;
  logic        cfl = 1'b0;
  logic        dfl = 1'b0;
  logic        hold_clock_low = 1'b0;
  logic        hold_data_low = 1'b0;
  logic [7:0]  cpu_rdata, rd;
  logic        tick, transfer_clock, clock_level, data_level;
  logic        scl_w, sda_w, scl_out, scl_oe, sda_out, sda_oe, seen0;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          per;
  int          nt = 0;

  always #10 mclk = ~mclk;

  bus_clock_setup u_bus_clock_setup (
    .mclk(mclk), .rst(rst), .ce(ce), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .interface_enable(en), .clock_function_low(cfl), .data_function_low(dfl),
    .selection_tick(tick), .transfer_clock(transfer_clock), .clock_level(clock_level),
    .data_level(data_level), .serial_clock_line_in(scl_w), .serial_clock_line_out(scl_out),
    .serial_clock_line_oe(scl_oe), .serial_data_line_in(sda_w),
    .serial_data_line_out(sda_out), .serial_data_line_oe(sda_oe));

  bus_partner u_bus_partner (
    .clock_oe(scl_oe), .clock_out(scl_out), .data_oe(sda_oe), .data_out(sda_out),
    .hold_clock_low(hold_clock_low), .hold_data_low(hold_data_low),
    .clock_wire(scl_w), .data_wire(sda_w));

  // -------------------------------------------------
  // Tasks
  // -------------------------------------------------
  task automatic close_out();
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge mclk);
    cpu_wr = 1'b0;
  endtask

  task automatic rdreg(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge mclk);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask

  task automatic rdchk(input string name, input logic [15:0] a, input logic [7:0] exp);
    rdreg(a, rd);
    check(name, {8'h00, rd}, {8'h00, exp});
  endtask

  // Program one divider setting while disabled, then time a full period
  task automatic period_chk(input logic [7:0] sel, input logic [7:0] clx,
                            input logic [15:0] exp);
    en = 1'b0;
    wr(bus_clock_pkg::ADDR_CLK_EXPANSION, clx);
    wr(bus_clock_pkg::ADDR_CLK_SELECT, sel);
    rdchk("sel_val", bus_clock_pkg::ADDR_CLK_SELECT, sel);
    en = 1'b1;
    measure(per);
    check("period", per[15:0], exp);
  endtask

  // Full transfer clock period in mclk cycles, rise to rise
  task automatic measure(output int n);
    int t;
    logic prev;
    n = 0;
    t = 0;
    prev = transfer_clock;
    while (t < 2000) begin
      @(negedge mclk);
      t++;
      if (n > 0) n++;
      if (prev === 1'b0 && transfer_clock === 1'b1) begin
        if (n > 0) break;
        n = 1;
      end
      prev = transfer_clock;
    end
    n = n - 1;
  endtask

  // One-cycle low pulse on the data line, note any low on the filtered level
  task automatic glitch(output logic s);
    s = 1'b0;
    @(negedge mclk) hold_data_low = 1'b1;
    @(negedge mclk) hold_data_low = 1'b0;
    repeat (8) begin
      @(negedge mclk);
      if (data_level !== 1'b1) s = 1'b1;
    end
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // -------------------------------------------------
  // Main sequence
  // -------------------------------------------------
  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    rdchk("data_rst", bus_clock_pkg::ADDR_PORT_SIX_DATA, 8'h03);
    rdchk("dir_rst", bus_clock_pkg::ADDR_PORT_SIX_DIR, 8'hff);
    rdchk("sel_rst", bus_clock_pkg::ADDR_CLK_SELECT, 8'h00);
    rdchk("exp_rst", bus_clock_pkg::ADDR_CLK_EXPANSION, 8'h00);
    rdchk("unmapped", 16'hffff, 8'h00);
    wr(bus_clock_pkg::ADDR_CLK_SELECT, 8'hfe);
    wr(bus_clock_pkg::ADDR_CLK_EXPANSION, 8'hff);
    rdchk("sel_ro", bus_clock_pkg::ADDR_CLK_SELECT, 8'h0e);
    rdchk("exp_bit", bus_clock_pkg::ADDR_CLK_EXPANSION, 8'h01);
    // Divider for nine select and expansion settings, periods in mclk cycles
    period_chk(8'h00, 8'h00, 16'h0058);
    period_chk(8'h01, 8'h00, 16'h00ac);
    period_chk(8'h02, 8'h00, 16'h0158);
    period_chk(8'h08, 8'h00, 16'h0030);
    period_chk(8'h09, 8'h00, 16'h0030);
    period_chk(8'h0a, 8'h00, 16'h0060);
    period_chk(8'h0c, 8'h00, 16'h0030);
    period_chk(8'h08, 8'h01, 16'h0018);
    period_chk(8'h0a, 8'h01, 16'h0030);
    // Selection ticks at one in four cycles
    nt = 0;
    repeat (40) @(negedge mclk) if (tick === 1'b1) nt++;
    check("ticks", nt[15:0], 16'h000a);
    // Line flags: enable first, then outputs
    en = 1'b0;
    wr(bus_clock_pkg::ADDR_CLK_EXPANSION, 8'h00);
    wr(bus_clock_pkg::ADDR_CLK_SELECT, 8'h00);
    en = 1'b1;
    wr(bus_clock_pkg::ADDR_PORT_SIX_DIR, 8'hf8);
    wr(bus_clock_pkg::ADDR_PORT_SIX_DATA, 8'h00);
    hold_data_low = 1'b1;
    repeat (5) @(negedge mclk);
    rdchk("flags_d0", bus_clock_pkg::ADDR_CLK_SELECT, 8'h20);
    hold_data_low = 1'b0;
    hold_clock_low = 1'b1;
    repeat (5) @(negedge mclk);
    check("clk_lvl", {15'h0, clock_level}, 16'h0000);
    rdchk("flags_c0", bus_clock_pkg::ADDR_CLK_SELECT, 8'h10);
    hold_clock_low = 1'b0;
    // Latch 1 outputs 1, latch 0 passes the serial function
    cfl = 1'b1;
    dfl = 1'b1;
    wr(bus_clock_pkg::ADDR_PORT_SIX_DATA, 8'h03);
    repeat (2) @(negedge mclk);
    check("oe_latch1", {14'h0, scl_oe, sda_oe}, 16'h0000);
    rdchk("data_out", bus_clock_pkg::ADDR_PORT_SIX_DATA, 8'h03);
    wr(bus_clock_pkg::ADDR_PORT_SIX_DATA, 8'h00);
    repeat (2) @(negedge mclk);
    check("oe_func", {14'h0, scl_oe, sda_oe}, 16'h0003);
    check("outs", {14'h0, scl_out, sda_out}, 16'h0000);
    // Disabled: output-mode pins held low, flags clear
    cfl = 1'b0;
    dfl = 1'b0;
    en = 1'b0;
    repeat (2) @(negedge mclk);
    check("oe_off", {14'h0, scl_oe, sda_oe}, 16'h0003);
    rdchk("flags_off", bus_clock_pkg::ADDR_CLK_SELECT, 8'h00);
    // Input mode: buffer off, data read gives pin level
    cfl = 1'b1;
    hold_data_low = 1'b1;
    wr(bus_clock_pkg::ADDR_PORT_SIX_DIR, 8'hff);
    repeat (4) @(negedge mclk);
    check("oe_in", {14'h0, scl_oe, sda_oe}, 16'h0000);
    rdchk("data_in", bus_clock_pkg::ADDR_PORT_SIX_DATA, 8'h01);
    cfl = 1'b0;
    hold_data_low = 1'b0;
    // Noise filter in high-speed mode
    wr(bus_clock_pkg::ADDR_CLK_SELECT, 8'h0c);
    repeat (4) @(negedge mclk);
    glitch(seen0);
    check("filt_on", {15'h0, seen0}, 16'h0000);
    wr(bus_clock_pkg::ADDR_CLK_SELECT, 8'h08);
    repeat (4) @(negedge mclk);
    glitch(seen0);
    check("filt_off", {15'h0, seen0}, 16'h0001);
    // Filter bit has no effect in standard mode
    wr(bus_clock_pkg::ADDR_CLK_SELECT, 8'h04);
    repeat (4) @(negedge mclk);
    glitch(seen0);
    check("filt_norm", {15'h0, seen0}, 16'h0001);
    // Clock enable low freezes all state
    wr(bus_clock_pkg::ADDR_CLK_SELECT, 8'h00);
    en = 1'b1;
    repeat (30) @(negedge mclk);
    ce = 1'b0;
    wr(bus_clock_pkg::ADDR_PORT_SIX_DIR, 8'hf8);
    repeat (100) @(negedge mclk);
    check("ce_tclk", {15'h0, transfer_clock}, 16'h0000);
    ce = 1'b1;
    rdchk("ce_dir", bus_clock_pkg::ADDR_PORT_SIX_DIR, 8'hff);
    // Stuck data line: pulse the clock pin through the port latch
    wr(bus_clock_pkg::ADDR_PORT_SIX_DIR, 8'hf8);
    cfl = 1'b1;
    hold_data_low = 1'b1;
    wr(bus_clock_pkg::ADDR_PORT_SIX_DATA, 8'h03);
    repeat (5) @(negedge mclk);
    check("rec_high", {15'h0, clock_level}, 16'h0001);
    wr(bus_clock_pkg::ADDR_PORT_SIX_DATA, 8'h02);
    repeat (5) @(negedge mclk);
    check("rec_low", {15'h0, clock_level}, 16'h0000);
    rdchk("rec_data", bus_clock_pkg::ADDR_PORT_SIX_DATA, 8'h02);
    cfl = 1'b0;
    hold_data_low = 1'b0;
    // Mid-run reset restores the port registers
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    rdchk("dir_rst2", bus_clock_pkg::ADDR_PORT_SIX_DIR, 8'hff);
    rdchk("flags_rst2", bus_clock_pkg::ADDR_CLK_SELECT, 8'h30);
    close_out();
  end
endmodule
